// ==== hw/sws_params.svh ====
// constants of the single-wire push/pull bus block
`ifndef SWS_PARAMS_SVH
`define SWS_PARAMS_SVH

// register indices, byte address is four times the index
`define SWS_IDX_DIVISOR 8'hC0
`define SWS_IDX_STATUS 8'hC4
`define SWS_IDX_MODECTL 8'hC5
`define SWS_IDX_DATA 8'hC7
`define SWS_IDX_CONFIG 8'hC8
`define SWS_IDX_IRQ_STAT 8'hC9
`define SWS_IDX_IRQ_MASK 8'hCA

// mode control and config field positions
`define SWS_B_WAIT_HALT 7
`define SWS_B_MODE_EN 6
`define SWS_B_DLY_HI 5
`define SWS_B_DLY_LO 4
`define SWS_B_RX_ACTIVE 0
`define SWS_CONFIG_MASK 8'hF0
`define SWS_MODECTL_RESET 8'h00

// serial status field positions
`define SWS_B_RX_FULL 5
`define SWS_B_BIT_ERR 3
`define SWS_B_NOISE 2

// interrupt status and mask positions
`define SWS_I_PUSH_DONE 0
`define SWS_I_PULL_DONE 1
`define SWS_I_BUS_ERR 2
`define SWS_I_NOISE 3

// frame shape
`define SWS_TICKS_PER_SLOT 16
`define SWS_SLOTS_PER_BIT 2
`define SWS_PUSH_BITS 8
`define SWS_PULL_BITS 4
`define SWS_PULL_FIXED 4'h5
`define SWS_PULL_ALL_ONES 3'h7
`define SWS_RX_ERROR 8'hFF

// timing
`define SWS_CLK_NS 20
`define SWS_SLOT_NS 25000
`define SWS_DIV_DEFAULT (`SWS_SLOT_NS / (`SWS_CLK_NS * `SWS_TICKS_PER_SLOT))

`endif

// ==== hw/sws_pkg.sv ====
// types of the single-wire push/pull bus block
package sws_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PUSH = 3'b010,
    ST_PULL = 3'b100
  } sws_state_type;
endpackage

// ==== hw/sws_link_if.sv ====
// carrier between the core, the baud divider and the receive synchroniser
`timescale 1ns/1ps
`default_nettype none
interface sws_link_if;
  logic tick16;
  logic rx_level;
  logic [12:0] divisor;
  logic halt;
  modport baud (input divisor, input halt, output tick16);
  modport sync (output rx_level);
  modport core (input tick16, input rx_level, output divisor, output halt);
endinterface
`default_nettype wire

// ==== hw/sws_baud.sv ====
// baud divider giving sixteen ticks per time slot
`timescale 1ns/1ps
`default_nettype none
module sws_baud (
  input wire logic clk_i,
  input wire logic rst_i,
  sws_link_if.baud link
);
  logic [12:0] cnt_reg;
  logic tick_reg;

  assign link.tick16 = tick_reg;

  // divide by divisor, stop at zero
  always_ff @(posedge clk_i) begin
    if (rst_i || link.divisor == 13'h0000 || link.halt) begin
      cnt_reg <= 13'h0000;
      tick_reg <= 1'b0;
    end else if (cnt_reg >= link.divisor - 13'h0001) begin
      // >= so that a smaller divisor written mid-count wraps at once
      cnt_reg <= 13'h0000;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 13'h0001;
      tick_reg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== hw/sws_rxsync.sv ====
// two-stage synchroniser for the receive pin
`timescale 1ns/1ps
`default_nettype none
module sws_rxsync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic serial_rx_pin_i,
  sws_link_if.sync link
);
  logic meta_reg;
  logic sync_reg;

  assign link.rx_level = sync_reg;

  // idle wire is recessive, so reset to one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= serial_rx_pin_i;
      sync_reg <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ==== hw/sws_core.sv ====
// single-wire push/pull bus port with classic Wishbone register slave
//
// Overview of operation
// - bit error flags sent/monitored mismatch in push field; never interrupts.
// - noise flag set when samples disagree during pull field.
// - wait-halt bit stops the serial clock while processor waits.
// - mode-enable bit switches the port to push/pull bus behaviour.
// - pull sampling delayed one to four sixteenths of a slot.
// - each bit spans two 25 us slots, slot rate 40 kHz.
// - receiver active bit high only while a pull field is received.
// - mode control register resets to zero, read-only.
// - valid pull reads 0101, status in bits 3..1, bit 0 one.
// - bus error makes receive data read all ones.
// - pull bits arrive lsb first into data bits 1 to 3.
// - push field sends five data bits then three address bits.
// - data from written bits 4..0, address from bits 7..5.
// - data address writes transmit register, reads receive register.
// - status read then data read clears only flags seen set.
// - time base is clock over sixteen times divisor; zero stops.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sws_params.svh"
module sws_core #(
  parameter logic [12:0] DIV_RESET = 13'(`SWS_DIV_DEFAULT)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic wait_mode_i,
  input wire logic serial_rx_pin_i,
  output logic serial_tx_pin_o,
  output logic irq_o
);

  // ****************************************************************
  // submodules
  // ****************************************************************
  sws_link_if link ();

  sws_baud u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .link(link.baud)
  );

  sws_rxsync u_rxsync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .serial_rx_pin_i(serial_rx_pin_i),
    .link(link.sync)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  sws_pkg::sws_state_type state_reg;
  logic [12:0] divisor_reg;
  logic [7:0] config_reg;
  logic receive_full_flag_reg;
  logic bit_error_flag_reg;
  logic noise_error_flag_reg;
  logic [2:0] armed_reg;
  logic [7:0] rx_data_reg;
  logic [7:0] tx_shift_reg;
  logic [4:0] pos_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] samples_reg;
  logic [2:0] status_shift_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
    return adr[9:2] == idx;
  endfunction

  logic access;
  logic wr;
  logic rd;
  logic bus_mode_enable;
  logic [2:0] dly;

  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = access & wb_we_i & wb_sel_i[0];
  assign rd = access & ~wb_we_i;
  assign bus_mode_enable = config_reg[`SWS_B_MODE_EN];
  // code plus one gives the factor
  assign dly = {1'b0, config_reg[`SWS_B_DLY_HI], config_reg[`SWS_B_DLY_LO]} + 3'h1;

  assign link.divisor = divisor_reg;
  // halt when enabled and waiting
  // idle holds the divider too, so every frame starts on a whole tick
  assign link.halt = (config_reg[`SWS_B_WAIT_HALT] & wait_mode_i)
    | (state_reg == sws_pkg::ST_IDLE);

  // ****************************************************************
  // frame events
  // ****************************************************************
  logic tick;
  logic slot_mid;
  logic bit_end;
  logic bit_err_evt;
  logic push_done_evt;
  logic sample_now;
  logic pull_end_evt;
  logic majority;
  logic noise_evt;
  logic bus_err_evt;
  logic rx_active;

  always_comb begin
    tick = link.tick16;
    slot_mid = tick & (pos_reg[3:0] == 4'h8);
    // sixteen ticks a slot, two slots a bit
    bit_end = tick & (pos_reg == 5'(`SWS_TICKS_PER_SLOT * `SWS_SLOTS_PER_BIT - 1));
    // compare wire with level being driven
    bit_err_evt = (state_reg == sws_pkg::ST_PUSH) & slot_mid
      & (link.rx_level != serial_tx_pin_o);
    push_done_evt = (state_reg == sws_pkg::ST_PUSH) & bit_end
      & (bit_cnt_reg == 3'(`SWS_PUSH_BITS - 1));
    // three samples starting at the delay
    sample_now = (state_reg == sws_pkg::ST_PULL) & tick
      & ((pos_reg == {2'b00, dly}) | (pos_reg == {2'b00, dly} + 5'h01)
      | (pos_reg == {2'b00, dly} + 5'h02));
    majority = (samples_reg[0] & samples_reg[1]) | (samples_reg[0] & samples_reg[2])
      | (samples_reg[1] & samples_reg[2]);
    noise_evt = (state_reg == sws_pkg::ST_PULL) & bit_end
      & ~((samples_reg == 3'h0) | (samples_reg == 3'h7));
    pull_end_evt = (state_reg == sws_pkg::ST_PULL) & bit_end
      & (bit_cnt_reg == 3'(`SWS_PULL_BITS - 1));
    // all-ones status with end of frame high
    bus_err_evt = pull_end_evt & (status_shift_reg == `SWS_PULL_ALL_ONES) & majority;
    rx_active = (state_reg == sws_pkg::ST_PULL);
  end

  // ****************************************************************
  // frame sequencer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= sws_pkg::ST_IDLE;
      pos_reg <= 5'h00;
      bit_cnt_reg <= 3'h0;
      tx_shift_reg <= 8'h00;
      samples_reg <= 3'h0;
      status_shift_reg <= 3'h0;
      serial_tx_pin_o <= 1'b1;
    end else begin
      case (state_reg)
        sws_pkg::ST_IDLE: begin
          serial_tx_pin_o <= 1'b1;
          pos_reg <= 5'h00;
          bit_cnt_reg <= 3'h0;
          // data write loads the transmit register
          // no frame runs with the mode off
          if (wr && hit(wb_adr_i, `SWS_IDX_DATA) && bus_mode_enable) begin
            tx_shift_reg <= wb_dat_i[7:0];
            state_reg <= sws_pkg::ST_PUSH;
          end
        end
        sws_pkg::ST_PUSH: begin
          // biphase: inverted level in the first slot, true in the second
          serial_tx_pin_o <= pos_reg[4] ? tx_shift_reg[0] : ~tx_shift_reg[0];
          if (!bus_mode_enable) begin
            state_reg <= sws_pkg::ST_IDLE;
          end else if (tick) begin
            pos_reg <= pos_reg + 5'h01;
            if (bit_end) begin
              // lsb first, data bits then address bits
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (push_done_evt) begin
                bit_cnt_reg <= 3'h0;
                state_reg <= sws_pkg::ST_PULL;
              end
            end
          end
        end
        sws_pkg::ST_PULL: begin
          // released wire, slaves pull it low
          serial_tx_pin_o <= 1'b1;
          if (!bus_mode_enable) begin
            state_reg <= sws_pkg::ST_IDLE;
          end else if (tick) begin
            pos_reg <= pos_reg + 5'h01;
            if (sample_now) begin
              samples_reg <= {samples_reg[1:0], link.rx_level};
            end
            if (bit_end) begin
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              // first bit lands in data bit 1
              if (!pull_end_evt) begin
                status_shift_reg <= {majority, status_shift_reg[2:1]};
              end else begin
                state_reg <= sws_pkg::ST_IDLE;
              end
            end
          end
        end
        default: begin
          state_reg <= sws_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // receive data
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_reg <= 8'h00;
    end else if (pull_end_evt) begin
      rx_data_reg <= bus_err_evt ? `SWS_RX_ERROR
        : {`SWS_PULL_FIXED, status_shift_reg, 1'b1};
    end
  end

  // ****************************************************************
  // serial status flags
  // ****************************************************************
  logic rd_status;
  logic rd_data;

  assign rd_status = rd & hit(wb_adr_i, `SWS_IDX_STATUS);
  assign rd_data = rd & hit(wb_adr_i, `SWS_IDX_DATA);

  // clear only what was armed, new events win
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receive_full_flag_reg <= 1'b0;
      bit_error_flag_reg <= 1'b0;
      noise_error_flag_reg <= 1'b0;
      armed_reg <= 3'h0;
    end else begin
      if (rd_status) begin
        armed_reg <= {receive_full_flag_reg, bit_error_flag_reg, noise_error_flag_reg};
      end else if (rd_data) begin
        armed_reg <= 3'h0;
      end
      receive_full_flag_reg <= (receive_full_flag_reg & ~(rd_data & armed_reg[2]))
        | pull_end_evt;
      bit_error_flag_reg <= (bit_error_flag_reg & ~(rd_data & armed_reg[1]))
        | bit_err_evt;
      noise_error_flag_reg <= (noise_error_flag_reg & ~(rd_data & armed_reg[0]))
        | noise_evt;
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      divisor_reg <= DIV_RESET;
      config_reg <= `SWS_MODECTL_RESET;
      irq_mask_reg <= 4'h0;
    end else if (wr) begin
      // mode control and status take no writes
      // mode bit lives in the config word
      if (hit(wb_adr_i, `SWS_IDX_CONFIG)) begin
        config_reg <= wb_dat_i[7:0] & `SWS_CONFIG_MASK;
      end
      // zero divisor disables the time base
      if (hit(wb_adr_i, `SWS_IDX_DIVISOR)) begin
        divisor_reg <= wb_dat_i[12:0];
      end
      if (hit(wb_adr_i, `SWS_IDX_IRQ_MASK)) begin
        irq_mask_reg <= wb_dat_i[3:0];
      end
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [3:0] irq_evt;

  always_comb begin
    irq_evt = 4'h0;
    irq_evt[`SWS_I_PUSH_DONE] = push_done_evt;
    irq_evt[`SWS_I_PULL_DONE] = pull_end_evt;
    irq_evt[`SWS_I_BUS_ERR] = bus_err_evt;
    irq_evt[`SWS_I_NOISE] = noise_evt;
  end

  // bit error has no interrupt source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_reg <= (rd && hit(wb_adr_i, `SWS_IDX_IRQ_STAT) ? 4'h0 : irq_stat_reg)
        | irq_evt;
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ****************************************************************
  // bus answer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= access;
      if (rd) begin
        case (wb_adr_i[9:2])
          `SWS_IDX_DIVISOR: wb_dat_o <= {19'h00000, divisor_reg};
          `SWS_IDX_STATUS: begin
            wb_dat_o <= 32'h00000000;
            wb_dat_o[`SWS_B_RX_FULL] <= receive_full_flag_reg;
            wb_dat_o[`SWS_B_BIT_ERR] <= bit_error_flag_reg;
            wb_dat_o[`SWS_B_NOISE] <= noise_error_flag_reg;
          end
          // live receiver state in bit 0
          `SWS_IDX_MODECTL: wb_dat_o <= {24'h000000, config_reg[7:4], 3'h0, rx_active};
          // data read returns the receive register
          `SWS_IDX_DATA: wb_dat_o <= {24'h000000, rx_data_reg};
          `SWS_IDX_CONFIG: wb_dat_o <= {24'h000000, config_reg};
          `SWS_IDX_IRQ_STAT: wb_dat_o <= {28'h0000000, irq_stat_reg};
          `SWS_IDX_IRQ_MASK: wb_dat_o <= {28'h0000000, irq_mask_reg};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ==== bench/sws_slave_model.sv ====
// far-side slave on the single wire: echoes the push field, answers the pull field
`timescale 1ns/1ps
`default_nettype none
module sws_slave_model #(
  parameter int DIV = 2
) (
  input wire logic clk_i,
  input wire logic tx_i,
  input wire logic lead_i,
  input wire logic err_i,
  input wire logic noise_i,
  input wire logic [3:0] pull_i,
  output logic rx_o,
  output logic [7:0] push_o
);
  // one bit is two slots of sixteen ticks
  localparam int BITC = 32 * DIV;
  logic drv;
  // wired-and with a pull-up: released wire reads recessive
  assign rx_o = tx_i & drv;
  initial begin
    drv = 1'b1;
    push_o = 8'h00;
    forever begin
      @(negedge tx_i);
      // lead: a zero first bit shows its falling edge only at mid-bit
      drv <= !err_i;
      // five data bits then three address bits, taken in the second slot
      for (int t = lead_i ? BITC / 2 : 0; t < 8 * BITC; t++) begin
        if (t % BITC == 3 * BITC / 4) begin
          push_o[t / BITC] = tx_i;
        end
        @(posedge clk_i);
      end
      // status bits first to third, then end of frame
      for (int k = 0; k < 4; k++) begin
        for (int c = 0; c < BITC; c++) begin
          // noise flips once a tick, so three samples never agree
          drv <= (noise_i && k == 0) ? ((c / DIV) % 2 == 1) : pull_i[k];
          @(posedge clk_i);
        end
      end
      drv <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== bench/sws_core_assertions.sv ====
// port-level checks for the push/pull bus core
`timescale 1ns/1ps
`default_nettype none
module sws_core_assertions #(
  parameter logic [12:0] DIV_RESET = 13'h002
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic serial_tx_pin_o,
  input wire logic irq_o
);
  localparam logic [15:0] SLOT_CLK = 16'(16 * DIV_RESET);
  logic [15:0] gap;
  logic [7:0] idx;
  assign idx = wb_adr_i[9:2];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // clocks since the wire last moved; saturates
  always_ff @(posedge clk_i) begin
    if (rst_i || $changed(serial_tx_pin_o)) begin
      gap <= 16'h0000;
    end else if (gap != 16'hFFFF) begin
      gap <= gap + 16'h0001;
    end
  end
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_read(logic [7:0] r);
    s_take ##0 (!wb_we_i && idx == r);
  endsequence
  a_ack_next_edge: assert property (s_take |=> wb_ack_o)
    else $error("request not answered at next edge");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_modectl_fixed: assert property (s_read(8'hC5) |=> wb_dat_o[31:8] == 24'h0
    && wb_dat_o[3:1] == 3'h0) else $error("mode control reserved bits set");
  a_data_shape: assert property (s_read(8'hC7) |=> wb_dat_o[31:8] == 24'h0
    && (wb_dat_o[7:0] inside {8'hFF, 8'h00} || (wb_dat_o[7:4] == 4'h5 && wb_dat_o[0])))
    else $error("receive data malformed");
  a_unmapped_zero: assert property (s_take ##0 (!wb_we_i && !(idx inside
    {8'hC0, 8'hC4, 8'hC5, 8'hC7, 8'hC8, 8'hC9, 8'hCA})) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_slot_length: assert property ($changed(serial_tx_pin_o) |-> gap >= SLOT_CLK - 16'h1)
    else $error("wire level shorter than a slot");
  a_irq_read_clear: assert property (s_read(8'hC9) |-> ##[1:3] !irq_o)
    else $error("interrupt stays after status read");
  a_reset_idle: assert property ($fell(rst_i) |-> serial_tx_pin_o && !irq_o && !wb_ack_o)
    else $error("outputs not idle after reset");
endmodule
bind sws_core sws_core_assertions #(.DIV_RESET(DIV_RESET)) chk_u (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .serial_tx_pin_o(serial_tx_pin_o), .irq_o(irq_o));
`default_nettype wire

// ==== bench/test_sws_core.sv ====
// self-checking bench for the push/pull bus core
`timescale 1ns/1ps
`default_nettype none
`include "sws_params.svh"
module test_sws_core;
  // four clocks a tick leave room for the far side and the two-flop sync
  localparam int DV = 4;
  localparam int PUSH_CLK = 256 * DV;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wait_mode_i;
  logic rx, tx, irq_o, lead, err, noise, hb;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i, pull;
  logic [31:0] wb_dat_i, wb_dat_o, x;
  logic [7:0] push, d, cfg, mask;
  int n_mismatch, check_count;
  sws_core #(.DIV_RESET(13'(DV))) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wait_mode_i(wait_mode_i), .serial_rx_pin_i(rx), .serial_tx_pin_o(tx), .irq_o(irq_o));
  sws_slave_model #(.DIV(DV)) slave_u (.clk_i(clk_i), .tx_i(tx), .lead_i(lead),
    .err_i(err), .noise_i(noise), .pull_i(pull), .rx_o(rx), .push_o(push));
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ****
  // wishbone master: waits as long as the slave needs
  // ****
  task automatic bus(input logic we, input logic [7:0] idx, input logic [31:0] wd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    x = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(x, exp);
  endtask
  function automatic logic [31:0] exp_data(input logic [3:0] p);
    return (p == 4'hF) ? 32'hFF : {24'h0, 4'h5, p[2:0], 1'b1};
  endfunction
  // one push/pull frame; i picks the corner case
  task automatic frame(input int i);
    logic [3:0] ie;
    int n;
    d = 8'($urandom);
    // frozen frames open with a high slot, so the far side waits for the thaw
    if (i == 4 || i == 5) d[0] = 1'b0;
    pull = {1'b1, (i == 1) ? 3'h7 : 3'($urandom)};
    if (i == 3) pull[2:1] = 2'b00;
    lead = !d[0];
    err = (i == 2);
    noise = (i == 3);
    hb = i[0] || i == 4;
    cfg = {hb, 1'b1, 2'(i), 4'h0};
    mask = (i == 6) ? 8'h0 : 8'hF;
    bus(1'b1, `SWS_IDX_CONFIG, {24'h0, cfg});
    bus(1'b1, `SWS_IDX_IRQ_MASK, {24'h0, mask});
    wait_mode_i <= i == 4 || !hb;
    if (i == 5) bus(1'b1, `SWS_IDX_DIVISOR, 32'h0);
    bus(1'b1, `SWS_IDX_DATA, {24'h0, d});
    if (i == 4 || i == 5) begin
      repeat (PUSH_CLK + 100) @(posedge clk_i);
      chk(`SWS_IDX_IRQ_STAT, 32'h0);
      if (i == 5) chk(`SWS_IDX_DIVISOR, 32'h0);
      wait_mode_i <= 1'b0;
      bus(1'b1, `SWS_IDX_DIVISOR, 32'(DV));
    end
    repeat (PUSH_CLK + 40) @(posedge clk_i);
    chk(`SWS_IDX_MODECTL, {24'h0, cfg | 8'h1});
    n = 0;
    do begin
      bus(1'b0, `SWS_IDX_MODECTL, 32'h0);
      n++;
    end while (x[0] !== 1'b0 && n < 200);
    check({31'h0, x[0]}, 32'h0);
    ie = {noise, pull == 4'hF, 2'b11};
    check({31'h0, irq_o}, {31'h0, |(ie & mask[3:0])});
    chk(`SWS_IDX_IRQ_STAT, {28'h0, ie});
    chk(`SWS_IDX_STATUS, {26'h0, 2'b10, err, noise, 2'b00});
    bus(1'b0, `SWS_IDX_DATA, 32'h0);
    if (!noise) check(x, exp_data(pull));
    chk(`SWS_IDX_STATUS, 32'h0);
    check({24'h0, push}, {24'h0, d});
  endtask
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // whole run is near 16k clocks; over twice that means a hang
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    test_done();
  end
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 10'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    wait_mode_i = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    void'($urandom(33695));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(`SWS_IDX_MODECTL, 32'h0);
    chk(8'hC1, 32'h0);
    bus(1'b1, `SWS_IDX_MODECTL, 32'hFF);
    chk(`SWS_IDX_MODECTL, 32'h0);
    bus(1'b1, `SWS_IDX_CONFIG, 32'hB0);
    bus(1'b1, `SWS_IDX_DATA, 32'h5A);
    repeat (PUSH_CLK) @(posedge clk_i);
    chk(`SWS_IDX_MODECTL, 32'hB0);
    chk(`SWS_IDX_IRQ_STAT, 32'h0);
    for (int i = 0; i < 8; i++) begin
      frame(i);
    end
    test_done();
  end
endmodule
`default_nettype wire
